// [bb_remap.sv]
/*
 * Bit-band alias remapper between the processor data bus and memories.
 * Upstream: request held until one-cycle mDone; one access outstanding.
 * Downstream: sReq held until one-cycle sAck from same-clock logic.
 */
`default_nettype none

module bb_remap
    import bb_pkg::*;
(
    input wire logic clk, // system clock
    input wire logic srst, // synchronous reset, active high
    input wire logic mReq, // master request, held until mDone
    input wire logic [31:0] mAddr, // master address
    input wire logic mWrite, // master write
    input wire logic [1:0] mSize, // master size code
    input wire logic [31:0] mWdata, // master write data, lane aligned
    input wire logic mInstr, // request is an instruction fetch
    output logic mDone, // one-cycle completion
    output logic mErr, // completion is a refusal
    output logic [31:0] mRdata, // read data, valid with mDone
    output logic sReq, // slave request, held until sAck
    output logic [31:0] sAddr, // slave address
    output logic sWrite, // slave write
    output logic [1:0] sSize, // slave size code
    output logic [31:0] sWdata, // slave write data
    output logic sLock, // keeps other masters off during update
    input wire logic sAck, // slave completion pulse
    input wire logic [31:0] sRdata // slave read data, valid with sAck
);

    // ************************************************************
    // decode and merge
    // ************************************************************
    bb_map_if map ();

    bb_decode u_decode (
        .addr (mAddr),
        .size (mSize),
        .instr (mInstr),
        .map (map)
    );

    logic bitPosHit;
    logic [31:0] mergedData;
    logic curBit;
    logic [4:0] bitPos_ff;
    logic newBit_ff;
    logic isWrite_ff;

    bb_bit_merge u_merge (
        .rdata (sRdata),
        .bitPos (bitPos_ff),
        .newBit (newBit_ff),
        .wdata (mergedData),
        .bitOut (curBit)
    );

    bb_state_t state_ff;
    bb_state_t nxt_state;
    logic take;

    assign take = (state_ff == ST_IDLE) && mReq;
    assign bitPosHit = curBit;

    // ************************************************************
    // sequencer
    // ************************************************************
    always_comb
    begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE:
            begin
                if (mReq)
                begin
                    if (map.refuse)
                        nxt_state = ST_DONE;
                    else if (map.isAlias)
                        nxt_state = ST_BREAD;
                    else
                        nxt_state = ST_PASS;
                end
            end
            ST_PASS:
            begin
                if (sAck)
                    nxt_state = ST_DONE;
            end
            ST_BREAD:
            begin
                if (sAck)
                    nxt_state = isWrite_ff ? ST_BWRITE : ST_DONE;
            end
            ST_BWRITE:
            begin
                if (sAck)
                    nxt_state = ST_DONE;
            end
            ST_DONE:
                nxt_state = ST_IDLE;
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            state_ff <= ST_IDLE;
        else
            state_ff <= nxt_state;
    end

    // ************************************************************
    // captured alias target
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            bitPos_ff <= 5'h00;
            newBit_ff <= 1'b0;
            isWrite_ff <= 1'b0;
        end
        else if (take)
        begin
            bitPos_ff <= map.bitPos;
            newBit_ff <= mWdata[0];
            isWrite_ff <= mWrite;
        end
    end

    // ************************************************************
    // downstream port
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sReq <= 1'b0;
            sAddr <= 32'h0000_0000;
            sWrite <= 1'b0;
            sSize <= SIZE_WORD;
            sWdata <= 32'h0000_0000;
            sLock <= 1'b0;
        end
        else
        begin
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (mReq && !map.refuse)
                    begin
                        sReq <= 1'b1;
                        sSize <= mSize;
                        if (map.isAlias)
                        begin
                            // alias always starts with a read of the band location
                            sAddr <= map.tgtAddr;
                            sWrite <= 1'b0;
                            sWdata <= 32'h0000_0000;
                            sLock <= mWrite;
                        end
                        else
                        begin
                            sAddr <= mAddr;
                            sWrite <= mWrite;
                            sWdata <= mWdata;
                            sLock <= 1'b0;
                        end
                    end
                end
                ST_BREAD:
                begin
                    if (sAck)
                    begin
                        // write half follows with no idle cycle between
                        sReq <= isWrite_ff;
                        sWrite <= isWrite_ff;
                        sWdata <= mergedData;
                    end
                end
                ST_PASS, ST_BWRITE:
                begin
                    if (sAck)
                    begin
                        sReq <= 1'b0;
                        sWrite <= 1'b0;
                        sLock <= 1'b0;
                    end
                end
                default:
                begin
                    sReq <= 1'b0;
                    sLock <= 1'b0;
                end
            endcase
        end
    end

    // ************************************************************
    // upstream answer
    // ************************************************************
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mDone <= 1'b0;
            mErr <= 1'b0;
            mRdata <= 32'h0000_0000;
        end
        else
        begin
            mDone <= 1'b0;
            mErr <= 1'b0;
            unique case (state_ff)
                ST_IDLE:
                begin
                    if (mReq && map.refuse)
                    begin
                        mDone <= 1'b1;
                        mErr <= 1'b1;
                        mRdata <= 32'h0000_0000;
                    end
                end
                ST_PASS:
                begin
                    if (sAck)
                    begin
                        mDone <= 1'b1;
                        mRdata <= sRdata;
                    end
                end
                ST_BREAD:
                begin
                    if (sAck)
                    begin
                        // writes still answer only after the write half completes
                        mDone <= !isWrite_ff;
                        mRdata <= bitPosHit ? ALIAS_READ_SET : ALIAS_READ_CLR;
                    end
                end
                ST_BWRITE:
                begin
                    if (sAck)
                    begin
                        mDone <= 1'b1;
                        mRdata <= 32'h0000_0000;
                    end
                end
                default:
                begin
                    mDone <= 1'b0;
                end
            endcase
        end
    end

endmodule : bb_remap

`default_nettype wire

// [bb_pkg.sv]
/*
 * Constants shared by the bit-band remapper: region bounds, alias field
 * positions, access sizes and state codes.
 * Assumes one system clock, synchronous active-high reset, 32-bit bus.
 */
`default_nettype none

package bb_pkg;

    // ************************************************************
    // address map
    // ************************************************************
    localparam logic [31:0] SRAM_BAND_BASE = 32'h2000_0000;
    localparam logic [31:0] SRAM_BAND_LAST = 32'h2000_7FFF;
    localparam logic [31:0] SRAM_ALIAS_BASE = 32'h2200_0000;
    localparam logic [31:0] SRAM_ALIAS_LAST = 32'h23FF_FFFF;
    localparam logic [31:0] PERI_BAND_BASE = 32'h4000_0000;
    localparam logic [31:0] PERI_BAND_LAST = 32'h400F_FFFF;
    localparam logic [31:0] PERI_ALIAS_BASE = 32'h4200_0000;
    localparam logic [31:0] PERI_ALIAS_LAST = 32'h43FF_FFFF;

    // ************************************************************
    // alias address fields: offset = byte * 32 + bit * 4
    // ************************************************************
    localparam int BYTE_OFS_LSB = 5;
    localparam int BYTE_OFS_MSB = 24;
    localparam int BIT_NUM_LSB = 2;
    localparam int BIT_NUM_MSB = 4;

    localparam logic [31:0] ALIAS_READ_SET = 32'h0000_0001;
    localparam logic [31:0] ALIAS_READ_CLR = 32'h0000_0000;

    typedef enum logic [1:0] {
        SIZE_BYTE = 2'h0,
        SIZE_HALF = 2'h1,
        SIZE_WORD = 2'h2
    } bb_size_t;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_PASS = 3'h1,
        ST_BREAD = 3'h2,
        ST_BWRITE = 3'h3,
        ST_DONE = 3'h4
    } bb_state_t;

endpackage : bb_pkg

`default_nettype wire

// [bb_map_if.sv]
/*
 * Decode result carried from the address decoder to the remapper core.
 * Assumes both ends sit on the same clock; the bundle is purely combinational.
 */
`default_nettype none

interface bb_map_if;
    logic isAlias;
    logic refuse;
    logic [31:0] tgtAddr;
    logic [4:0] bitPos;

    modport dec (output isAlias, output refuse, output tgtAddr, output bitPos);
    modport use_m (input isAlias, input refuse, input tgtAddr, input bitPos);
endinterface : bb_map_if

`default_nettype wire

// [bb_decode.sv]
/*
 * Combinational alias decoder: region hit, refusal and target byte/bit.
 * Assumes the request fields are stable while the core samples them.
 */
`default_nettype none

module bb_decode
    import bb_pkg::*;
(
    input wire logic [31:0] addr, // request address
    input wire logic [1:0] size, // request size code
    input wire logic instr, // request is an instruction fetch
    bb_map_if.dec map // decode result
);
    logic inSram;
    logic inPeri;
    logic [31:0] bandBase;
    logic [31:0] byteAddr;

    assign inSram = (addr >= SRAM_ALIAS_BASE) && (addr <= SRAM_ALIAS_LAST);
    assign inPeri = (addr >= PERI_ALIAS_BASE) && (addr <= PERI_ALIAS_LAST);
    assign bandBase = inPeri ? PERI_BAND_BASE : SRAM_BAND_BASE;

    // fetches from the SRAM alias go through untouched
    assign map.isAlias = (inSram || inPeri) && !instr;
    assign map.refuse = inPeri && instr;

    // inverse of base + byte*32 + bit*4
    assign byteAddr = bandBase
        + {12'h000, addr[BYTE_OFS_MSB:BYTE_OFS_LSB]};

    always_comb
    begin
        map.tgtAddr = byteAddr;
        unique case (size)
            SIZE_HALF: map.tgtAddr = {byteAddr[31:1], 1'b0};
            SIZE_WORD: map.tgtAddr = {byteAddr[31:2], 2'h0};
            default: map.tgtAddr = byteAddr;
        endcase
    end

    // little-endian lanes: the byte's lane index forms the high bit-position bits
    assign map.bitPos = {byteAddr[1:0], addr[BIT_NUM_MSB:BIT_NUM_LSB]};

endmodule : bb_decode

`default_nettype wire

// [bb_bit_merge.sv]
/*
 * Bit extract and bit replace on a 32-bit lane-aligned data word.
 * Assumes data lanes follow the byte address (little-endian bus).
 */
`default_nettype none

module bb_bit_merge
(
    input wire logic [31:0] rdata, // data read from band location
    input wire logic [4:0] bitPos, // target bit within the lanes
    input wire logic newBit, // value to store
    output logic [31:0] wdata, // data to write back
    output logic bitOut // current value of the target bit
);
    genvar i;
    generate
        for (i = 0; i < 32; i++)
        begin : g_bit
            // only the addressed bit changes on write back
            assign wdata[i] = (bitPos == 5'(i)) ? newBit : rdata[i];
        end
    endgenerate

    assign bitOut = rdata[bitPos];

endmodule : bb_bit_merge

`default_nettype wire

// [bb_remap_checker.sv]
/* Assertions on the ports of bb_remap, bound to every instance.
   Assumes one clock and one request outstanding at a time. */
`default_nettype none
module bb_remap_checker
(
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic mReq, // req
    input wire logic [31:0] mAddr, // addr
    input wire logic mWrite, // write
    input wire logic [1:0] mSize, // size
    input wire logic [31:0] mWdata, // wdata
    input wire logic mInstr, // fetch
    input wire logic mDone, // done
    input wire logic mErr, // refused
    input wire logic [31:0] mRdata, // rdata
    input wire logic sReq, // slave req
    input wire logic [31:0] sAddr, // slave addr
    input wire logic sWrite, // slave write
    input wire logic [1:0] sSize, // slave size
    input wire logic [31:0] sWdata, // slave wdata
    input wire logic sLock, // lock
    input wire logic sAck, // slave ack
    input wire logic [31:0] sRdata // slave rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************************
    // request capture
    // ************************************************************
    logic busyFf = 1'b0;
    logic [31:0] aFf;
    logic [31:0] wFf;
    logic [31:0] rdFf;
    logic [1:0] zFf;
    logic iFf;
    logic wrFf;
    logic take;
    logic isAl;
    logic [31:0] band;
    logic [4:0] pos;
    assign take = mReq && !busyFf;
    assign isAl = aFf[31:25] == 7'h21 || (aFf[31:25] == 7'h11 && !iFf);
    assign band = {aFf[31:28], 8'h0, aFf[24:5]};
    assign pos = {band[1:0], aFf[4:2]};
    always_ff @(posedge clk)
    begin
        busyFf <= srst ? 1'b0 : take ? 1'b1 : mDone ? 1'b0 : busyFf;
    end
    always_ff @(posedge clk)
    begin
        if (take)
        begin
            aFf <= mAddr;
            wFf <= mWdata;
            zFf <= mSize;
            iFf <= mInstr;
            wrFf <= mWrite;
        end
    end
    // read half data, reused to predict the write back
    always_ff @(posedge clk)
    begin
        if (sAck && !sWrite)
            rdFf <= sRdata;
    end
    // ************************************************************
    // properties
    // ************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    sequence s_rdHalf;
        sReq && sAck && !sWrite && isAl && wrFf;
    endsequence
    sequence s_wrHalf;
        sReq && sWrite && sLock && sAddr == $past(sAddr);
    endsequence
    property p_rmw;
        s_rdHalf |-> sLock ##1 s_wrHalf;
    endproperty
    a_rmw: assert property (p_rmw) else $error("update halves broken");
    property p_refuse;
        take && mInstr && mAddr[31:25] == 7'h21 |=> mDone && mErr && !sReq;
    endproperty
    a_refuse: assert property (p_refuse) else $error("fetch not refused");
    property p_errCause;
        mErr |-> mDone && iFf && aFf[31:25] == 7'h21;
    endproperty
    a_errCause: assert property (p_errCause) else $error("stray refusal");
    property p_pass;
        sReq && !isAl |-> sAddr == aFf && sSize == zFf && sWrite == wrFf
            && (!wrFf || sWdata == wFf);
    endproperty
    a_pass: assert property (p_pass) else $error("pass access altered");
    property p_aliasAddr;
        sReq && isAl |-> sAddr == (band & ~((32'h1 << zFf) - 32'h1)) && sSize == zFf;
    endproperty
    a_aliasAddr: assert property (p_aliasAddr) else $error("bad band address");
    property p_merge;
        sReq && sWrite && isAl |-> sWdata == ((rdFf & ~(32'h1 << pos)) | (32'(wFf[0]) << pos));
    endproperty
    a_merge: assert property (p_merge) else $error("bad merged data");
    property p_readVal;
        mDone && !mErr && isAl && !wrFf |-> mRdata == {31'h0, rdFf[pos]};
    endproperty
    a_readVal: assert property (p_readVal) else $error("bad alias read");
    property p_passRd;
        mDone && !mErr && !isAl && !wrFf |-> mRdata == $past(sRdata);
    endproperty
    a_passRd: assert property (p_passRd) else $error("bad pass read");
endmodule : bb_remap_checker
bind bb_remap bb_remap_checker u_chk (.clk(clk), .srst(srst), .mReq(mReq), .mAddr(mAddr),
    .mWrite(mWrite), .mSize(mSize), .mWdata(mWdata), .mInstr(mInstr), .mDone(mDone),
    .mErr(mErr), .mRdata(mRdata), .sReq(sReq), .sAddr(sAddr), .sWrite(sWrite),
    .sSize(sSize), .sWdata(sWdata), .sLock(sLock), .sAck(sAck), .sRdata(sRdata));
`default_nettype wire

// [bb_mem_model.sv]
/* Behavioural memory at the slave side of the remapper.
   Assumes the same clock; acknowledges after dly waiting cycles. */
`default_nettype none
module bb_mem_model
(
    input wire logic clk, // clock
    input wire logic srst, // reset
    input wire logic [3:0] dly, // wait cycles
    input wire logic sReq, // req
    input wire logic [31:0] sAddr, // addr
    input wire logic sWrite, // write
    input wire logic [1:0] sSize, // size
    input wire logic [31:0] sWdata, // wdata
    output logic sAck, // ack
    output logic [31:0] sRdata, // rdata
    output logic [7:0] accCnt // acks seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [64];
    logic [31:0] lastFf = 32'h0;
    logic [3:0] cntFf;
    logic [5:0] idx;
    logic [3:0] be;
    initial
        for (int i = 0; i < 64; i++)
            mem[i] = 32'h5A5A_0000 | 32'(i);
    // small window: only a few words per region are told apart
    assign idx = {sAddr[30], sAddr[6:2]};
    assign sAck = sReq && cntFf == dly;
    // released data is inverted so a stale sample never passes
    assign sRdata = sAck ? mem[idx] : ~lastFf;
    assign be = sSize[1] ? 4'hF : sSize[0] ? 4'h3 << {sAddr[1], 1'b0} : 4'h1 << sAddr[1:0];
    always @(posedge clk)
    begin
        cntFf <= srst || sAck ? 4'h0 : cntFf + {3'h0, sReq};
        accCnt <= srst ? 8'h0 : accCnt + {7'h0, sAck};
        if (sAck)
        begin
            lastFf <= sRdata;
            for (int b = 0; b < 4; b++)
                if (sWrite && be[b])
                    mem[idx][8*b +: 8] <= sWdata[8*b +: 8];
        end
    end
endmodule : bb_mem_model
`default_nettype wire

// [bb_remap_bench.sv]
/* Self-checking bench for bb_remap with a memory model on its slave side.
   Assumes bb_pkg, the design and the memory model are compiled first. */
`default_nettype none
module bb_remap_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic mReq = 1'b0;
    logic [31:0] mAddr = 32'h0;
    logic mWrite = 1'b0;
    logic [1:0] mSize = 2'h2;
    logic [31:0] mWdata = 32'h0;
    logic mInstr = 1'b0;
    logic [3:0] dly = 4'h0;
    logic mDone, mErr, sReq, sWrite, sLock, sAck, errv;
    logic [31:0] mRdata, sAddr, sWdata, sRdata, rdv;
    logic [1:0] sSize;
    logic [7:0] accCnt;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    bb_remap u_dut (.clk(clk), .srst(srst), .mReq(mReq), .mAddr(mAddr), .mWrite(mWrite),
        .mSize(mSize), .mWdata(mWdata), .mInstr(mInstr), .mDone(mDone), .mErr(mErr),
        .mRdata(mRdata), .sReq(sReq), .sAddr(sAddr), .sWrite(sWrite), .sSize(sSize),
        .sWdata(sWdata), .sLock(sLock), .sAck(sAck), .sRdata(sRdata));
    bb_mem_model u_mem (.clk(clk), .srst(srst), .dly(dly), .sReq(sReq), .sAddr(sAddr),
        .sWrite(sWrite), .sSize(sSize), .sWdata(sWdata), .sAck(sAck), .sRdata(sRdata),
        .accCnt(accCnt));
    always #2.5 clk = ~clk;
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            stop_test();
        end
    end
    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // holds the request until mDone is sampled, then drops it
    task automatic acc(input logic [31:0] a, input logic w, input logic [1:0] z,
        input logic [31:0] d, input logic i);
        int n;
        n = 0;
        mAddr <= a;
        mWrite <= w;
        mSize <= z;
        mWdata <= d;
        mInstr <= i;
        mReq <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (mDone !== 1'b1 && n < 100);
        mReq <= 1'b0;
        rdv = mRdata;
        errv = mErr;
        if (n == 100)
        begin
            num_errors++;
            stop_test();
        end
        @(posedge clk);
    endtask : acc
    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_pass();
        acc(32'h2000_0004, 1'b1, 2'h2, 32'hA5C3_0F96, 1'b0);
        acc(32'h2000_0005, 1'b1, 2'h0, 32'h0000_7E00, 1'b0);
        acc(32'h2000_0004, 1'b0, 2'h2, 32'h0, 1'b0);
        check(rdv, 32'hA5C3_7E96);
        acc(32'h4000_0008, 1'b1, 2'h2, 32'h1234_5678, 1'b0);
        acc(32'h4000_000A, 1'b0, 2'h1, 32'h0, 1'b0);
        check({16'h0, rdv[31:16]}, 32'h1234);
        $display("pass test done");
    endtask : t_pass
    task automatic t_alias_rd();
        for (int b = 0; b < 8; b++)
        begin
            acc(32'h2200_0080 + 32'(b * 4), 1'b0, 2'h2, 32'h0, 1'b0);
            check(rdv, 32'((8'h96 >> b) & 8'h1));
        end
        acc(32'h23FF_FFFC, 1'b0, 2'h2, 32'h0, 1'b0);
        check(rdv, 32'h0);
        acc(32'h23FF_FFE4, 1'b0, 2'h0, 32'h0, 1'b0);
        check(rdv, 32'h1);
        acc(32'h2200_0080, 1'b0, 2'h2, 32'h0, 1'b1);
        check(rdv, 32'h5A5A_0000);
        $display("alias read test done");
    endtask : t_alias_rd
    task automatic t_alias_wr();
        logic [31:0] wd [4] = '{32'hFF, 32'h0E, 32'h01, 32'h00};
        logic [7:0] c0;
        dly <= 4'h2;
        foreach (wd[k])
        begin
            c0 = accCnt;
            acc(32'h2200_008C, 1'b1, 2'h2, wd[k], 1'b0);
            check(32'(accCnt - c0), 32'h2);
            acc(32'h2200_008C, 1'b0, 2'h2, 32'h0, 1'b0);
            check(rdv, {31'h0, wd[k][0]});
        end
        acc(32'h2000_0004, 1'b0, 2'h2, 32'h0, 1'b0);
        check(rdv, 32'hA5C3_7E96);
        dly <= 4'h0;
        $display("alias write test done");
    endtask : t_alias_wr
    task automatic t_peri();
        logic [7:0] c0;
        acc(32'h4200_0154, 1'b1, 2'h1, 32'hFFFF_FFFE, 1'b0);
        acc(32'h4000_0008, 1'b0, 2'h2, 32'h0, 1'b0);
        check(rdv, 32'h1214_5678);
        acc(32'h4200_0150, 1'b0, 2'h0, 32'h0, 1'b0);
        check(rdv, 32'h1);
        c0 = accCnt;
        acc(32'h4200_0150, 1'b0, 2'h2, 32'h0, 1'b1);
        check({31'h0, errv}, 32'h1);
        check(32'(accCnt), 32'(c0));
        $display("peripheral test done");
    endtask : t_peri
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        t_pass();
        t_alias_rd();
        t_alias_wr();
        t_peri();
        stop_test();
    end
endmodule : bb_remap_bench
`default_nettype wire
